// >>> core/cfg_target.sv
// Functional notes
// - Host opens writes with address d2
// - Command code byte sent and acknowledged
// - Byte count sent and acknowledged before data
// - Command and count acknowledged, then discarded
// - Data bytes ascending from byte 0, bytes 0 to 6 acknowledged
// - Keep complete bytes, leave later ones unchanged
// - Host ends every write with stop
// - Keep loading data bytes up to byte 6, then leave later bytes unacknowledged
// - Only block writes are supported
// - Host clocks at most 100 kbit/s
// - Every unit on the bus is eight bits
// - Latches readable through block read
// - Registers take defaults at reset
// - Host opens read-back with address d3
// - Read-back returns count, then bytes 0 to 6
// - Host acknowledges every byte, then stops
`timescale 1ns/10ps
module cfg_target (
    input  wire logic                          clk,
    input  wire logic                          rstn,
    smb_if.device                              bus,
    output logic     [smb_cfg_pkg::CFG_W-1:0]  cfg_q,
    output logic                               cfg_wr_q
);
    import smb_cfg_pkg::*;

    function automatic logic [7:0] cfg_byte(input logic [CFG_W-1:0] c, input logic [2:0] i);
        cfg_byte = c[{i, 3'b000} +: 8];
    endfunction: cfg_byte

    logic       scl_m_q;
    logic       scl_s_q;
    logic       scl_p_q;
    logic       sda_m_q;
    logic       sda_s_q;
    logic       sda_p_q;
    dev_state_t st_q;
    dev_state_t st_d;
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic [7:0] rx_q;
    logic [7:0] rx_d;
    logic [7:0] tx_q;
    logic [7:0] tx_d;
    logic [2:0] idx_q;
    logic [2:0] idx_d;
    logic       oe_q;
    logic       oe_d;
    logic       o_q;
    logic       o_d;
    logic       store_d;

    // Two-flop synchronisers, third stage for edge detection
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            scl_m_q <= 1'b1;
            scl_s_q <= 1'b1;
            scl_p_q <= 1'b1;
            sda_m_q <= 1'b1;
            sda_s_q <= 1'b1;
            sda_p_q <= 1'b1;
        end
        else
        begin
            scl_m_q <= bus.scl;
            scl_s_q <= scl_m_q;
            scl_p_q <= scl_s_q;
            sda_m_q <= bus.sda;
            sda_s_q <= sda_m_q;
            sda_p_q <= sda_s_q;
        end
    end

    wire scl_rise  = scl_s_q & ~scl_p_q;
    wire scl_fall  = ~scl_s_q & scl_p_q;
    wire scl_hi    = scl_s_q & scl_p_q;
    wire start_det = scl_hi & sda_p_q & ~sda_s_q;
    wire stop_det  = scl_hi & ~sda_p_q & sda_s_q;
    wire active    = (st_q != D_IDLE) && (st_q != D_HOLD);
    wire addr_ok   = (rx_q == WR_ADDR) || (rx_q == RD_ADDR);
    wire room      = (idx_q <= LAST_CFG);
    wire [2:0] idx_inc = (idx_q == 3'h7) ? idx_q : idx_q + 3'h1;
    wire [7:0] tx_next = room ? cfg_byte(cfg_q, idx_q) : FILL_BYTE;

    always_comb
    begin
        st_d    = st_q;
        cnt_d   = cnt_q;
        rx_d    = rx_q;
        tx_d    = tx_q;
        idx_d   = idx_q;
        oe_d    = oe_q;
        o_d     = o_q;
        store_d = 1'b0;
        if (start_det)
        begin
            st_d  = D_ADDR;
            cnt_d = 4'h0;
            oe_d  = 1'b0;
            o_d   = 1'b1;
        end
        else if (stop_det)
        begin
            // Stop ends any transfer, written bytes stay
            st_d  = D_IDLE;
            cnt_d = 4'h0;
            oe_d  = 1'b0;
            o_d   = 1'b1;
        end
        else if (active && scl_rise)
        begin
            if (cnt_q < ACK_BIT)
            begin
                rx_d  = {rx_q[6:0], sda_s_q};
                cnt_d = cnt_q + 4'h1;
            end
            else if (cnt_q == ACK_BIT)
            begin
                cnt_d = ACK_DONE;
                // Host not acknowledging ends the readout
                if (st_q == D_RDATA && sda_s_q)
                begin
                    st_d = D_HOLD;
                end
            end
        end
        else if (active && scl_fall)
        begin
            if (cnt_q == ACK_BIT)
            begin
                case (st_q)
                    D_ADDR:
                    begin
                        if (addr_ok)
                        begin
                            oe_d = 1'b1;
                            o_d  = 1'b0;
                        end
                        else
                        begin
                            st_d = D_IDLE;
                            oe_d = 1'b0;
                        end
                    end
                    D_CMD, D_CNT:
                    begin
                        // Acknowledged, contents dropped
                        oe_d = 1'b1;
                        o_d  = 1'b0;
                    end
                    D_WDATA:
                    begin
                        if (room)
                        begin
                            store_d = 1'b1;
                            idx_d   = idx_inc;
                            oe_d    = 1'b1;
                            o_d     = 1'b0;
                        end
                        else
                        begin
                            st_d = D_HOLD;
                            oe_d = 1'b0;
                        end
                    end
                    default:
                    begin
                        oe_d = 1'b0;
                        o_d  = 1'b1;
                    end
                endcase
            end
            else if (cnt_q == ACK_DONE)
            begin
                cnt_d = 4'h0;
                oe_d  = 1'b0;
                o_d   = 1'b1;
                case (st_q)
                    D_ADDR:
                    begin
                        if (rx_q == RD_ADDR)
                        begin
                            st_d  = D_RDATA;
                            tx_d  = RD_COUNT;
                            idx_d = 3'h0;
                            oe_d  = 1'b1;
                            o_d   = RD_COUNT[7];
                        end
                        else
                        begin
                            st_d = D_CMD;
                        end
                    end
                    D_CMD:
                    begin
                        st_d = D_CNT;
                    end
                    D_CNT:
                    begin
                        st_d  = D_WDATA;
                        idx_d = 3'h0;
                    end
                    D_RDATA:
                    begin
                        tx_d  = tx_next;
                        idx_d = idx_inc;
                        oe_d  = 1'b1;
                        o_d   = tx_next[7];
                    end
                    default:
                    begin
                        st_d = st_q;
                    end
                endcase
            end
            else if (st_q == D_RDATA && cnt_q != 4'h0)
            begin
                tx_d = {tx_q[6:0], 1'b0};
                oe_d = 1'b1;
                o_d  = tx_q[6];
            end
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st_q  <= D_IDLE;
            cnt_q <= 4'h0;
            rx_q  <= 8'h00;
            tx_q  <= 8'h00;
            idx_q <= 3'h0;
            oe_q  <= 1'b0;
            o_q   <= 1'b1;
        end
        else
        begin
            st_q  <= st_d;
            cnt_q <= cnt_d;
            rx_q  <= rx_d;
            tx_q  <= tx_d;
            idx_q <= idx_d;
            oe_q  <= oe_d;
            o_q   <= o_d;
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cfg_q    <= CFG_RESET;
            cfg_wr_q <= 1'b0;
        end
        else
        begin
            cfg_wr_q <= store_d;
            if (store_d)
            begin
                cfg_q[{idx_q, 3'b000} +: 8] <= rx_q;
            end
        end
    end

    assign bus.d_sda_o  = o_q;
    assign bus.d_sda_oe = oe_q;

endmodule: cfg_target

// >>> core/smb_cfg_pkg.sv
package smb_cfg_pkg;

    // Bus addresses of the configuration port
    localparam logic [7:0]  WR_ADDR       = 8'hd2;
    localparam logic [7:0]  RD_ADDR       = 8'hd3;

    // Configuration store: bytes 0 to 6
    localparam int          NUM_CFG       = 7;
    localparam int          CFG_W         = NUM_CFG * 8;
    localparam logic [2:0]  LAST_CFG      = 3'h6;
    localparam logic [7:0]  RD_COUNT      = 8'h07;
    localparam logic [55:0] CFG_RESET     = 56'h00_00_00_00_00_00_00;

    // Filler returned past the last byte, command code sent by the host
    localparam logic [7:0]  FILL_BYTE     = 8'hff;
    localparam logic [7:0]  CMD_CODE      = 8'h00;

    // Bit slots inside one nine-clock frame, last read frame and write header frame count
    localparam logic [3:0]  ACK_BIT       = 4'h8;
    localparam logic [3:0]  ACK_DONE      = 4'h9;
    localparam logic [3:0]  RD_LAST_FRAME = 4'h8;
    localparam logic [3:0]  WR_HDR_FRAMES = 4'h3;

    // Serial clock timing, 100 kbit/s at most
    localparam int          CLK_PERIOD_NS = 5;
    localparam int          SCL_PERIOD_NS = 10000;
    localparam int          QTR_CYC       = (SCL_PERIOD_NS / 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [9:0]  QTR_LAST      = 10'(QTR_CYC - 1);

    typedef enum logic [2:0] {
        D_IDLE,
        D_ADDR,
        D_CMD,
        D_CNT,
        D_WDATA,
        D_RDATA,
        D_HOLD
    } dev_state_t;

    typedef enum logic [2:0] {
        H_IDLE,
        H_START,
        H_BIT,
        H_WAIT,
        H_STOP
    } host_state_t;

endpackage: smb_cfg_pkg

// >>> core/smb_if.sv
`timescale 1ns/10ps
interface smb_if;
    logic scl_o;
    logic scl_oe;
    logic h_sda_o;
    logic h_sda_oe;
    logic d_sda_o;
    logic d_sda_oe;
    logic scl;
    logic sda;

    // Wired-AND with pull-up: a released or high-driving end leaves the line high
    assign scl = ~scl_oe | scl_o;
    assign sda = (~h_sda_oe | h_sda_o) & (~d_sda_oe | d_sda_o);

    modport device (input scl, input sda, output d_sda_o, output d_sda_oe);
    modport host   (input scl, input sda, output scl_o, output scl_oe, output h_sda_o, output h_sda_oe);
endinterface: smb_if

// >>> core/cfg_host.sv
`timescale 1ns/10ps
module cfg_host (
    input  wire logic                          clk,
    input  wire logic                          rstn,
    smb_if.host                                bus,
    input  wire logic                          cmd_valid,
    input  wire logic                          cmd_read,
    input  wire logic [2:0]                    cmd_len,
    input  wire logic [smb_cfg_pkg::CFG_W-1:0] cmd_data,
    output logic                               cmd_ready_q,
    output logic                               done_q,
    output logic                               nack_q,
    output logic                               rd_valid_q,
    output logic      [7:0]                    rd_data_q,
    input  wire logic                          rd_ready
);
    import smb_cfg_pkg::*;

    function automatic logic [7:0] frame_byte(input logic [3:0] f, input logic rd,
                                              input logic [2:0] len, input logic [CFG_W-1:0] d);
        logic [3:0] k;
        k = f - WR_HDR_FRAMES;
        if (f == 4'h0)
            frame_byte = rd ? RD_ADDR : WR_ADDR;
        else if (f == 4'h1)
            frame_byte = CMD_CODE;
        else if (f == 4'h2)
            frame_byte = {5'h00, len};
        else
            frame_byte = d[{k[2:0], 3'b000} +: 8];
    endfunction: frame_byte

    logic             sda_m_q;
    logic             sda_s_q;
    host_state_t      st_q;
    logic [9:0]       tk_q;
    logic [1:0]       ph_q;
    logic [3:0]       bit_q;
    logic [3:0]       fr_q;
    logic             rd_q;
    logic [2:0]       len_q;
    logic [CFG_W-1:0] data_q;
    logic [7:0]       sh_q;
    logic             scl_q;
    logic             sda_q;
    logic             sda_oe_q;
    logic [7:0]       sk_q;
    logic             sk_v_q;

    // Quarter-bit tick sets the serial rate
    wire        tick      = (tk_q == QTR_LAST);
    wire        frame_rx  = rd_q && (fr_q != 4'h0);
    wire [3:0]  last_fr   = rd_q ? RD_LAST_FRAME : {1'b0, len_q} + 4'h2;
    wire [3:0]  fr_inc    = fr_q + 4'h1;
    wire [7:0]  next_byte = frame_byte(fr_inc, rd_q, len_q, data_q);
    wire        frame_end = (st_q == H_BIT) && tick && (ph_q == 2'h3) && (bit_q == ACK_BIT);
    wire        push      = frame_end && frame_rx && (fr_q >= 4'h2);
    wire        pop       = rd_valid_q && rd_ready;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sda_m_q <= 1'b1;
            sda_s_q <= 1'b1;
        end
        else
        begin
            sda_m_q <= bus.sda;
            sda_s_q <= sda_m_q;
        end
    end

    // Two-entry read buffer: output slot plus skid slot
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rd_valid_q <= 1'b0;
            rd_data_q  <= 8'h00;
            sk_q       <= 8'h00;
            sk_v_q     <= 1'b0;
        end
        else if (pop && sk_v_q)
        begin
            rd_data_q <= sk_q;
            sk_q      <= sh_q;
            sk_v_q    <= push;
        end
        else if (pop || !rd_valid_q)
        begin
            rd_data_q  <= sh_q;
            rd_valid_q <= push;
        end
        else if (push)
        begin
            sk_q   <= sh_q;
            sk_v_q <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st_q        <= H_IDLE;
            tk_q        <= 10'h000;
            ph_q        <= 2'h0;
            bit_q       <= 4'h0;
            fr_q        <= 4'h0;
            rd_q        <= 1'b0;
            len_q       <= 3'h0;
            data_q      <= '0;
            sh_q        <= 8'h00;
            scl_q       <= 1'b1;
            sda_q       <= 1'b1;
            sda_oe_q    <= 1'b0;
            cmd_ready_q <= 1'b1;
            done_q      <= 1'b0;
            nack_q      <= 1'b0;
        end
        else
        begin
            done_q <= 1'b0;
            tk_q   <= (tick || st_q == H_IDLE || st_q == H_WAIT) ? 10'h000 : tk_q + 10'h001;
            if (tick)
            begin
                ph_q <= ph_q + 2'h1;
            end
            case (st_q)
                H_IDLE:
                begin
                    ph_q <= 2'h0;
                    if (cmd_valid && cmd_ready_q)
                    begin
                        cmd_ready_q <= 1'b0;
                        nack_q      <= 1'b0;
                        rd_q        <= cmd_read;
                        len_q       <= (cmd_len == 3'h0) ? 3'h1 : cmd_len;
                        data_q      <= cmd_data;
                        st_q        <= H_START;
                    end
                end
                H_START:
                begin
                    if (tick && ph_q == 2'h0)
                    begin
                        sda_oe_q <= 1'b1;
                        sda_q    <= 1'b0;
                    end
                    else if (tick && ph_q == 2'h1)
                    begin
                        scl_q <= 1'b0;
                        st_q  <= H_BIT;
                        ph_q  <= 2'h0;
                        bit_q <= 4'h0;
                        fr_q  <= 4'h0;
                        sh_q  <= frame_byte(4'h0, rd_q, len_q, data_q);
                    end
                end
                H_BIT:
                begin
                    if (tick && ph_q == 2'h0)
                    begin
                        // Drive data, release for the target, or acknowledge a read byte
                        sda_oe_q <= (bit_q < ACK_BIT) ? !frame_rx : frame_rx;
                        sda_q    <= (bit_q < ACK_BIT) ? sh_q[7] : 1'b0;
                    end
                    else if (tick && ph_q == 2'h1)
                    begin
                        scl_q <= 1'b1;
                    end
                    else if (tick && ph_q == 2'h2)
                    begin
                        if (bit_q < ACK_BIT)
                        begin
                            sh_q <= {sh_q[6:0], sda_s_q};
                        end
                        else if (!frame_rx && sda_s_q)
                        begin
                            nack_q <= 1'b1;
                        end
                    end
                    else if (tick && ph_q == 2'h3)
                    begin
                        scl_q <= 1'b0;
                        if (bit_q < ACK_BIT)
                        begin
                            bit_q <= bit_q + 4'h1;
                        end
                        else if (nack_q || fr_q == last_fr)
                        begin
                            st_q <= H_STOP;
                        end
                        else
                        begin
                            // Header frames then data in ascending order
                            fr_q  <= fr_inc;
                            bit_q <= 4'h0;
                            sh_q  <= next_byte;
                            st_q  <= rd_q ? H_WAIT : H_BIT;
                        end
                    end
                end
                H_WAIT:
                begin
                    ph_q <= 2'h0;
                    if (!sk_v_q)
                    begin
                        st_q <= H_BIT;
                    end
                end
                default:
                begin
                    if (tick && ph_q == 2'h0)
                    begin
                        sda_oe_q <= 1'b1;
                        sda_q    <= 1'b0;
                    end
                    else if (tick && ph_q == 2'h1)
                    begin
                        scl_q <= 1'b1;
                    end
                    else if (tick && ph_q == 2'h2)
                    begin
                        sda_oe_q <= 1'b0;
                        sda_q    <= 1'b1;
                    end
                    else if (tick && ph_q == 2'h3)
                    begin
                        st_q        <= H_IDLE;
                        done_q      <= 1'b1;
                        cmd_ready_q <= 1'b1;
                    end
                end
            endcase
        end
    end

    assign bus.scl_o    = scl_q;
    assign bus.scl_oe   = 1'b1;
    assign bus.h_sda_o  = sda_q;
    assign bus.h_sda_oe = sda_oe_q;

endmodule: cfg_host

// >>> tb/cfg_port_props.sv
`timescale 1ns/10ps
module cfg_port_props
    import smb_cfg_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic scl,
    input wire logic sda,
    input wire logic d_sda_o,
    input wire logic d_sda_oe
);
    logic        scl_p_q;
    logic        sda_p_q;
    logic [3:0]  bit_q;
    logic [3:0]  frm_q;
    logic [7:0]  sh_q;
    logic [7:0]  adr_q;
    logic [11:0] per_q;
    wire         rise    = scl & ~scl_p_q;
    wire         fall    = ~scl & scl_p_q;
    wire         edge_sp = scl & scl_p_q & (sda ^ sda_p_q);
    wire         d_low   = d_sda_oe & ~d_sda_o;
    wire         is_wr   = adr_q == WR_ADDR;
    wire         is_rd   = adr_q == RD_ADDR;
    wire         mid     = frm_q != 4'h0;
    wire         ours_sh = sh_q == WR_ADDR || sh_q == RD_ADDR;
    wire         last_b  = bit_q == ACK_BIT;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
            per_q   <= 12'hfff;
        end
        else
        begin
            scl_p_q <= scl;
            sda_p_q <= sda;
            per_q   <= rise ? 12'h001 : per_q + {11'h000, per_q != 12'hfff};
        end
    end

    // Bit and frame position, restarted by start or stop
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            bit_q <= 4'h0;
            frm_q <= 4'h0;
            sh_q  <= 8'h00;
            adr_q <= 8'h00;
        end
        else if (edge_sp)
        begin
            bit_q <= 4'h0;
            frm_q <= 4'h0;
        end
        else if (rise)
        begin
            bit_q <= last_b ? 4'h0 : bit_q + 4'h1;
            frm_q <= frm_q + {3'h0, last_b && frm_q != 4'hf};
            sh_q  <= last_b ? sh_q : {sh_q[6:0], sda};
            adr_q <= last_b && !mid ? sh_q : adr_q;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence s_ack_slot;
        fall && last_b && ((!mid && ours_sh) || (is_wr && mid && frm_q <= 4'h9));
    endsequence
    sequence s_ack_held;
        d_low ##1 d_low [*8];
    endsequence
    property p_addr_ack;
        rise && last_b && !mid |-> d_low == ours_sh;
    endproperty
    property p_hdr_ack;
        rise && last_b && is_wr && mid && frm_q <= 4'h9 |-> d_low;
    endproperty
    property p_wr_quiet;
        rise && !last_b && (!mid || is_wr) |-> !d_sda_oe;
    endproperty
    property p_rd_count;
        rise && last_b && is_rd && frm_q == 4'h1 |-> sh_q == RD_COUNT && !d_sda_oe;
    endproperty
    property p_ack_window;
        s_ack_slot |-> ##[1:8] s_ack_held;
    endproperty
    property p_ack_end;
        fall && bit_q == 4'h0 && mid && is_wr |-> ##[1:8] !d_sda_oe;
    endproperty
    property p_rate;
        rise |-> per_q >= 12'(SCL_PERIOD_NS / CLK_PERIOD_NS);
    endproperty
    property p_reset_idle;
        $rose(rstn) |-> !d_sda_oe && sda && scl;
    endproperty

    a_addr_ack: assert property (p_addr_ack) else $error("address ack wrong");
    a_hdr_ack: assert property (p_hdr_ack) else $error("write byte not acked");
    a_wr_quiet: assert property (p_wr_quiet) else $error("target drives host bit");
    a_rd_count: assert property (p_rd_count) else $error("read count wrong");
    a_ack_window: assert property (p_ack_window) else $error("ack late or short");
    a_ack_end: assert property (p_ack_end) else $error("ack not released");
    a_rate: assert property (p_rate) else $error("serial clock too fast");
    a_reset_idle: assert property (p_reset_idle) else $error("bus busy after reset");
endmodule: cfg_port_props

// >>> tb/clock_gen_block_write_serial_port_tb.sv
`timescale 1ns/10ps
module clock_gen_block_write_serial_port_tb;
    import smb_cfg_pkg::*;
    logic             clk = 1'b0;
    logic             rstn = 1'b0;
    logic             cmd_valid = 1'b0;
    logic             cmd_read = 1'b0;
    logic [2:0]       cmd_len = 3'h0;
    logic [CFG_W-1:0] cmd_data = '0;
    logic             rd_ready = 1'b0;
    logic             cmd_ready_q;
    logic             done_q;
    logic             nack_q;
    logic             rd_valid_q;
    logic             cfg_wr_q;
    logic [7:0]       rd_data_q;
    logic [CFG_W-1:0] cfg_q;
    logic [CFG_W-1:0] model;
    logic [CFG_W-1:0] wr_note[$];
    logic [7:0]       rd_note[$];
    int               n_errors = 0;
    int               checked = 0;

    smb_if bus ();
    cfg_target cfg_target_inst (.clk(clk), .rstn(rstn), .bus(bus), .cfg_q(cfg_q), .cfg_wr_q(cfg_wr_q));
    cfg_host cfg_host_inst (.clk(clk), .rstn(rstn), .bus(bus), .cmd_valid(cmd_valid), .cmd_read(cmd_read),
        .cmd_len(cmd_len), .cmd_data(cmd_data), .cmd_ready_q(cmd_ready_q), .done_q(done_q), .nack_q(nack_q),
        .rd_valid_q(rd_valid_q), .rd_data_q(rd_data_q), .rd_ready(rd_ready));
    cfg_port_props cfg_port_props_inst (.clk(clk), .rstn(rstn), .scl(bus.scl), .sda(bus.sda),
        .d_sda_o(bus.d_sda_o), .d_sda_oe(bus.d_sda_oe));

    always #2.5 clk = ~clk;

    task automatic check_val(input string what, input logic [CFG_W-1:0] seen, input logic [CFG_W-1:0] expected);
        checked++;
        if (seen !== expected)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, expected, seen);
        end
    endtask: check_val

    task automatic complete_run;
        if (n_errors == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask: complete_run

    // Notes expected results, then runs one host command to completion
    task automatic run_cmd(input logic rd, input logic [2:0] len);
        logic [CFG_W-1:0] data;
        int               k;
        data = CFG_W'({$urandom, $urandom});
        for (k = 0; k < NUM_CFG; k++)
        begin
            if (rd)
                rd_note.push_back(model[8*k +: 8]);
            else if (k < len)
            begin
                model[8*k +: 8] = data[8*k +: 8];
                wr_note.push_back(model);
            end
        end
        cmd_read  <= rd;
        cmd_len   <= len;
        cmd_data  <= data;
        cmd_valid <= 1'b1;
        do
            @(posedge clk);
        while (cmd_ready_q !== 1'b1);
        cmd_valid <= 1'b0;
        for (k = 0; k < 400000 && done_q !== 1'b1; k++)
            @(posedge clk);
        // A command that never finishes counts here
        check_val("done and ready", CFG_W'({done_q, cmd_ready_q}), CFG_W'(2'h3));
        check_val("nack flag", CFG_W'(nack_q), '0);
    endtask: run_cmd

    always @(posedge clk)
    begin
        if (cfg_wr_q === 1'b1)
            check_val("config latches", cfg_q, wr_note.pop_front());
        if (rd_valid_q === 1'b1 && rd_ready === 1'b1)
            check_val("read byte", CFG_W'(rd_data_q), CFG_W'(rd_note.pop_front()));
    end

    initial
    begin
        void'($urandom(49));
        // Random receiver stalls on the read stream
        fork
            forever
            begin
                @(posedge clk);
                rd_ready <= 1'($urandom_range(1));
            end
        join_none
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        model = CFG_RESET;
        check_val("reset latches", cfg_q, CFG_RESET);
        repeat (8) @(posedge clk);
        run_cmd(1'b0, 3'h7);
        run_cmd(1'b0, 3'h2);
        run_cmd(1'b1, 3'h0);
        repeat (50) @(posedge clk);
        check_val("latches after read", cfg_q, model);
        check_val("notes left", CFG_W'(wr_note.size() + rd_note.size()), '0);
        complete_run();
    end

    initial
    begin
        repeat (1000000) @(posedge clk);
        n_errors++;
        complete_run();
    end
endmodule: clock_gen_block_write_serial_port_tb
